/* File: rtl/lfs_channel.sv */
// Per-channel good/open/short classifier with open time-out
`timescale 1ns/1ps
`default_nettype none
module lfs_channel
  import lfs_pkg::*;
#(
  parameter int OPEN_CYC = OPEN_TO_CYC,
  parameter int HOT_CYC  = HOT_TO_CYC
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire lfs_chan_cmp_s cmp,
  input  wire logic          shortSel,
  input  wire logic          shortOff,
  input  wire logic          stable,
  input  wire logic          forceOpen,
  input  wire logic          hot,
  input  wire logic          active,
  output logic               good,
  output logic               failOpen,
  output logic               failShort
);
  localparam int TW = $clog2(OPEN_CYC + 1);

  logic          openPend;
  logic [TW-1:0] timer;

  //////////////////////////////////////////////////////////////////////
  // Classification terms
  wire logic [TW-1:0] limit    = hot ? TW'(HOT_CYC)
                                     : TW'(OPEN_CYC);
  wire logic          expired  = openPend && (timer >= limit - TW'(1));
  wire logic          dropOpen = good && cmp.below50;
  wire logic          forced   = forceOpen && !good;
  wire logic          overV    = shortSel ? cmp.aboveLow
                                          : cmp.aboveHigh;
  wire logic          shortNow = active && !shortOff && overV;
  wire logic          next_failOpen  = active && expired && stable;
  wire logic          next_failShort = shortNow && stable;

  // Good flag, pending open and time-out counter
  always_ff @(posedge mclk) begin
    if (!rstn || !active) begin
      good      <= 1'b0;
      openPend  <= 1'b0;
      timer     <= '0;
      failOpen  <= 1'b0;
      failShort <= 1'b0;
    end else begin
      failOpen  <= next_failOpen;
      failShort <= next_failShort;
      if (dropOpen || forced)
        good <= 1'b0;
      else if (cmp.above75)
        good <= 1'b1;
      if (dropOpen || forced)
        openPend <= 1'b1;
      else if (cmp.above75)
        openPend <= 1'b0;
      // Time-out restarts from zero for every new open event
      if (!openPend)
        timer <= '0;
      else if (!expired)
        timer <= timer + TW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_short_disable: assert property (
    shortNow && stable |=> failShort)
    else $error("short channel not disabled");
  a_open_nottimed: assert property (
    failOpen |-> $past(openPend) && $past(timer) >= $past(limit) - 1)
    else $error("open channel disabled before time-out");
  a_fault_held: assert property (
    !stable |=> !failOpen && !failShort)
    else $error("fault acted while feedback unstable");
  a_good_mark: assert property (
    active && cmp.above75 && !good && !forceOpen ##1 active |-> good)
    else $error("channel not marked good");
endmodule
`default_nettype wire

/* File: rtl/lfs_pkg.sv */
// Package: constants and carrier types for the LED fault supervisor
package lfs_pkg;

  //////////////////////////////////////////////////////////////////////
  // Register map and field layout
  localparam int         NCH          = 8;
  localparam logic [7:0] ADDR_FAULT   = 8'h02;
  localparam logic [7:0] ADDR_CONFIG  = 8'h08;
  localparam logic [7:0] ADDR_MASK    = 8'h09;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] FAULT_RESET  = 8'h00;
  localparam logic [7:0] READ_NONE    = 8'h00;
  localparam int         CFG_SHORT_SEL = 0;  // 0: 8.0 V, 1: 3.1 V
  localparam int         CFG_SHORT_OFF = 1;  // 1: short detect disabled
  // Fault/status bit positions
  localparam int FLT_OPEN     = 0;
  localparam int FLT_SHORT    = 1;
  localparam int FLT_OVP      = 2;
  localparam int FLT_OVERCUR  = 3;
  localparam int FLT_SWNODE   = 4;
  localparam int FLT_OVPDROP  = 5;

  //////////////////////////////////////////////////////////////////////
  // Current limit ladder, 375 mA per step, 3 A at the top
  localparam int         ILIM_STEP_MA = 375;
  localparam logic [2:0] ILIM_FIRST   = 3'h0;
  localparam logic [2:0] ILIM_LAST    = 3'h7;
  localparam int         SS_STEPS     = 7;

  //////////////////////////////////////////////////////////////////////
  // Timing at 200 MHz
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint SS_TOTAL_NS   = 1000000;  // 1 ms ramp
  localparam longint OPEN_TO_NS    = 6000000;  // 6 ms open time-out
  localparam longint HOT_TO_NS     = 800000;   // 800 us when hot
  // Ramp step: longest time, rounded down
  localparam int SS_STEP_CYC =
    int'(SS_TOTAL_NS * 1000 / CLK_PERIOD_PS / SS_STEPS);
  // Time-outs: least times, rounded up
  localparam int OPEN_TO_CYC =
    int'((OPEN_TO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int HOT_TO_CYC =
    int'((HOT_TO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  //////////////////////////////////////////////////////////////////////
  // Supply sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_PRECHARGE = 4'h1,
    ST_SOFTSTART = 4'h2,
    ST_RUN       = 4'h4,
    ST_TRIP      = 4'h8
  } lfs_state_e;

  // Comparator results of one channel
  typedef struct packed {
    logic above75;    // current at least 75 % of target
    logic below50;    // current below 50 % of target
    logic aboveLow;   // channel voltage above 3.1 V
    logic aboveHigh;  // channel voltage above 8.0 V
  } lfs_chan_cmp_s;

  // Register access from the SMBus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lfs_reg_req_s;

endpackage

/* File: rtl/lfs_supervisor.sv */
// Top: supply sequencing, current limit ramp and string fault supervisor
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int SS_CYC   = SS_STEP_CYC,
  parameter int OPEN_CYC = OPEN_TO_CYC,
  parameter int HOT_CYC  = HOT_TO_CYC
) (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     supplyLockout,
  input  wire lfs_reg_req_s             regReq,
  output logic [7:0]                    regRdData,
  input  wire logic                     swCycleTick,
  input  wire logic                     switchOverLimit,
  input  wire logic                     switchNodeHigh,
  input  wire logic                     disconnectFullyOn,
  input  wire logic                     overvoltageSense20,
  input  wire logic                     outputOverVoltage,
  input  wire logic                     tempAboveLow,
  input  wire logic                     inputOverCurrent,
  input  wire logic                     feedbackStable,
  input  wire lfs_chan_cmp_s [NCH-1:0]  chanCmp,
  output logic                          disconnectEnable,
  output logic                          prechargeEnable,
  output logic                          powerSwitchOn,
  output logic [2:0]                    currentLimitStep,
  output logic [NCH-1:0]                chanEnable
);
  localparam int SW = $clog2(SS_CYC + 1);

  //////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] setBit(input logic [7:0] v,
                                        input int         pos,
                                        input logic       ev);
    logic [7:0] r;
    r      = v;
    r[pos] = v[pos] | ev;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // State
  lfs_state_e     state;
  lfs_state_e     next_state;
  logic [SW-1:0]  ssCnt;
  logic           ovpSeen;
  logic [7:0]     faultStatus;
  logic [7:0]     configuration;
  logic [7:0]     channelMask;
  logic [7:0]     next_channelMask;
  logic [NCH-1:0] chanGood;
  logic [NCH-1:0] chanFailOpen;
  logic [NCH-1:0] chanFailShort;

  // Lockout acts as a synchronous reset of the whole block
  wire logic coreRstn = rstn && !supplyLockout;

  //////////////////////////////////////////////////////////////////////
  // Sequencer decode
  wire logic inPre      = (state == ST_PRECHARGE);
  wire logic inSoft     = (state == ST_SOFTSTART);
  wire logic inRun      = (state == ST_RUN);
  wire logic switching  = inSoft || inRun;
  wire logic ssTerm     = (ssCnt == SW'(SS_CYC - 1));
  wire logic startOk    = disconnectFullyOn && switchNodeHigh;
  wire logic swNodeFail = switching && !powerSwitchOn
                          && !switchNodeHigh;
  wire logic ovpDrop    = switching && ovpSeen
                          && !overvoltageSense20;
  wire logic overCur    = switching && inputOverCurrent;
  wire logic trip       = swNodeFail || ovpDrop || overCur;
  wire logic stepUp     = inSoft && ssTerm;
  wire logic lastStep   = (currentLimitStep == ILIM_LAST);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_PRECHARGE: begin
        if (startOk)
          next_state = ST_SOFTSTART;
      end
      ST_SOFTSTART: begin
        if (trip)
          next_state = ST_TRIP;
        else if (stepUp && currentLimitStep == ILIM_LAST - 3'h1)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (trip)
          next_state = ST_TRIP;
      end
      ST_TRIP: next_state = ST_TRIP;
      default: next_state = ST_PRECHARGE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (!coreRstn) begin
      state <= ST_PRECHARGE;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Soft-start current limit ladder
  always_ff @(posedge mclk) begin
    if (!coreRstn || !switching) begin
      ssCnt            <= '0;
      currentLimitStep <= ILIM_FIRST;
    end else begin
      ssCnt <= (ssTerm || lastStep) ? '0 : ssCnt + SW'(1);
      if (stepUp && !lastStep)
        currentLimitStep <= currentLimitStep + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Power switch, cycle by cycle current limit
  wire logic next_powerSwitchOn =
    !switching || switchOverLimit ? 1'b0 :
    swCycleTick                   ? 1'b1 : powerSwitchOn;

  always_ff @(posedge mclk) begin
    if (!coreRstn) begin
      powerSwitchOn <= 1'b0;
    end else begin
      powerSwitchOn <= next_powerSwitchOn;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Supply pins: pre-charge source and disconnect switch drive
  always_ff @(posedge mclk) begin
    if (!coreRstn) begin
      prechargeEnable  <= 1'b0;
      disconnectEnable <= 1'b0;
    end else begin
      prechargeEnable  <= (next_state == ST_PRECHARGE);
      disconnectEnable <= (next_state != ST_TRIP);
    end
  end

  // Overvoltage sense seen above 20 percent
  always_ff @(posedge mclk) begin
    if (!coreRstn) begin
      ovpSeen <= 1'b0;
    end else if (overvoltageSense20) begin
      ovpSeen <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Channels
  wire logic           forceOpen  = outputOverVoltage || tempAboveLow;
  wire logic [NCH-1:0] chanActive = ~channelMask
                                    & {NCH{switching}};
  wire logic [NCH-1:0] chanFail   = chanFailOpen | chanFailShort;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      lfs_channel #(
        .OPEN_CYC (OPEN_CYC),
        .HOT_CYC  (HOT_CYC)
      ) u_chan (
        .mclk      (mclk),
        .rstn      (coreRstn),
        .cmp       (chanCmp[gi]),
        .shortSel  (configuration[CFG_SHORT_SEL]),
        .shortOff  (configuration[CFG_SHORT_OFF]),
        .stable    (feedbackStable),
        .forceOpen (forceOpen),
        .hot       (tempAboveLow),
        .active    (chanActive[gi]),
        .good      (chanGood[gi]),
        .failOpen  (chanFailOpen[gi]),
        .failShort (chanFailShort[gi])
      );
    end
  endgenerate

  // Channel enables follow mask and sequencer
  always_ff @(posedge mclk) begin
    if (!coreRstn) begin
      chanEnable <= '0;
    end else begin
      chanEnable <= ~next_channelMask & {NCH{next_state == ST_SOFTSTART
                    || next_state == ST_RUN}};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register decode
  wire logic wrConfig = regReq.wr && (regReq.addr == ADDR_CONFIG);
  wire logic wrMask   = regReq.wr && (regReq.addr == ADDR_MASK);
  assign next_channelMask =
    (wrMask ? regReq.wdata : channelMask) | chanFail;
  wire logic [7:0] faultEv0 = setBit(faultStatus, FLT_OPEN,
                                     |chanFailOpen);
  wire logic [7:0] faultEv1 = setBit(faultEv0, FLT_SHORT,
                                     |chanFailShort);
  wire logic [7:0] faultEv2 = setBit(faultEv1, FLT_OVP,
                                     outputOverVoltage);
  wire logic [7:0] faultEv3 = setBit(faultEv2, FLT_OVERCUR, overCur);
  wire logic [7:0] faultEv4 = setBit(faultEv3, FLT_SWNODE,
                                     swNodeFail);
  wire logic [7:0] next_faultStatus = setBit(faultEv4, FLT_OVPDROP,
                                             ovpDrop);
  wire logic [7:0] readMux =
    (regReq.addr == ADDR_FAULT)  ? faultStatus   :
    (regReq.addr == ADDR_CONFIG) ? configuration :
    (regReq.addr == ADDR_MASK)   ? channelMask   : READ_NONE;

  // Register storage
  always_ff @(posedge mclk) begin
    if (!coreRstn) begin
      configuration <= CONFIG_RESET;
      channelMask   <= MASK_RESET;
      faultStatus   <= FAULT_RESET;
      regRdData     <= READ_NONE;
    end else begin
      if (wrConfig)
        configuration <= regReq.wdata;
      channelMask <= next_channelMask;
      faultStatus <= next_faultStatus;
      if (regReq.rd)
        regRdData <= readMux;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!coreRstn);

  sequence s_ovpRise;
    overvoltageSense20 ##1 1'b1;
  endsequence
  sequence s_ovpFall;
    !overvoltageSense20 && switching;
  endsequence

  a_ilim_first: assert property (
    inPre ##1 inSoft |-> currentLimitStep == ILIM_FIRST)
    else $error("ramp does not start at lowest limit");
  a_ilim_ramp: assert property (
    inSoft && !trip && !ssTerm |=> $stable(currentLimitStep))
    else $error("limit stepped off schedule");
  a_inrush_wait: assert property (
    inPre && !startOk |=> !switching)
    else $error("switching before disconnect fully on");
  a_switch_limit: assert property (
    switchOverLimit |=> !powerSwitchOn)
    else $error("switch not cut at limit");
  a_mask_fail: assert property (
    |chanFail |=> (channelMask & $past(chanFail)) == $past(chanFail))
    else $error("failed channel not shown in mask");
  a_ovcur_off: assert property (
    overCur |=> chanEnable == '0 && faultStatus[FLT_OVERCUR])
    else $error("overcurrent left channels on");
  a_swnode_trip: assert property (
    swNodeFail |=> !disconnectEnable && faultStatus[FLT_SWNODE])
    else $error("switch node fault ignored");
  a_ovp_collapse: assert property (
    s_ovpRise ##[0:8] s_ovpFall |=> !disconnectEnable)
    else $error("overvoltage sense collapse ignored");
  a_trip_sticks: assert property (
    state == ST_TRIP |=> state == ST_TRIP && !powerSwitchOn)
    else $error("tripped supervisor restarted");
endmodule
`default_nettype wire

/* File: tb/led_driver_fault_supervisor_test.sv */
// Self-checking bench for the LED fault supervisor
`timescale 1ns/1ps
`default_nettype none
module led_driver_fault_supervisor_test import lfs_pkg::*;;
  localparam int SSC = 8;
  localparam int OPC = 20;
  localparam int HTC = 10;
  logic mclk, rstn, supplyLockout, swCycleTick, switchOverLimit;
  logic switchNodeHigh, disconnectFullyOn, overvoltageSense20;
  logic outputOverVoltage, tempAboveLow, inputOverCurrent;
  logic feedbackStable, nodeFail, slow;
  logic disconnectEnable, prechargeEnable, powerSwitchOn;
  lfs_reg_req_s            regReq;
  logic [7:0]              regRdData;
  lfs_chan_cmp_s [NCH-1:0] chanCmp;
  logic [2:0]              currentLimitStep;
  logic [NCH-1:0]          chanEnable;
  int                      badCount = 0;
  int                      checksDone = 0;
  int                      cyc = 0;

  lfs_supervisor #(.SS_CYC(SSC), .OPEN_CYC(OPC), .HOT_CYC(HTC)) i_dut (
    .mclk(mclk), .rstn(rstn), .supplyLockout(supplyLockout),
    .regReq(regReq), .regRdData(regRdData), .swCycleTick(swCycleTick),
    .switchOverLimit(switchOverLimit), .switchNodeHigh(switchNodeHigh),
    .disconnectFullyOn(disconnectFullyOn),
    .overvoltageSense20(overvoltageSense20),
    .outputOverVoltage(outputOverVoltage), .tempAboveLow(tempAboveLow),
    .inputOverCurrent(inputOverCurrent), .feedbackStable(feedbackStable),
    .chanCmp(chanCmp), .disconnectEnable(disconnectEnable),
    .prechargeEnable(prechargeEnable), .powerSwitchOn(powerSwitchOn),
    .currentLimitStep(currentLimitStep), .chanEnable(chanEnable));
  lfs_power_stage i_stage (
    .mclk(mclk), .disconnectEnable(disconnectEnable),
    .prechargeEnable(prechargeEnable), .powerSwitchOn(powerSwitchOn),
    .nodeFail(nodeFail), .slow(slow), .swCycleTick(swCycleTick),
    .switchOverLimit(switchOverLimit), .switchNodeHigh(switchNodeHigh),
    .disconnectFullyOn(disconnectFullyOn));

  //////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      badCount++;
      finalReport();
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    if (n > 0)
      #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    regReq.wr = 1'b0;
    tick(1);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e,
                       input string m);
    regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    chk(regRdData, e, m);
    regReq.rd = 1'b0;
    tick(1);
  endtask
  task automatic offWindow(input int ch, input int lo, input int hi,
                           input string m);
    int i;
    tick(lo);
    chk(8'(chanEnable[ch]), 8'h01, m);
    for (i = lo; i < hi && chanEnable[ch]; i++) tick(1);
    chk(8'(chanEnable[ch]), 8'h00, m);
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic startUp(input logic [7:0] goodMask);
    int n;
    for (n = 0; n < NCH; n++) chanCmp[n] = '{goodMask[n], 1'b0, 1'b0, 1'b0};
    supplyLockout = 1'b1;
    tick(2);
    chk(chanEnable | {6'h0, prechargeEnable, disconnectEnable}, 8'h00,
        "lockout");
    supplyLockout = 1'b0;
    tick(1);
    chk({4'h0, powerSwitchOn, currentLimitStep}, 8'h00, "held off");
    tick(1);
    chk({6'h0, prechargeEnable, disconnectEnable}, 8'h03, "precharge");
    for (n = 0; n < 60 && prechargeEnable; n++) tick(1);
    chk({5'h0, currentLimitStep}, {5'h0, ILIM_FIRST}, "first limit");
    for (n = 0; n < 100 && currentLimitStep !== ILIM_LAST; n++) tick(1);
    chk(8'(n >= 7 * SSC - 2 && n <= 7 * SSC + 1), 8'h01, "ramp time");
    rdChk(ADDR_FAULT, FAULT_RESET, "fault reset");
    rdChk(ADDR_CONFIG, CONFIG_RESET, "config reset");
    rdChk(ADDR_MASK, MASK_RESET, "mask reset");
    $display("startup done");
  endtask
  task automatic testSwitch(input logic s, input int lo, input int hi);
    int n;
    int d;
    slow = s;
    for (n = 0; n < 40 && powerSwitchOn; n++) tick(1);
    for (n = 0; n < 40 && !powerSwitchOn; n++) tick(1);
    for (d = 0; d < 20 && powerSwitchOn; d++) tick(1);
    chk(8'(d >= lo && d <= hi), 8'h01, "on-time");
    slow = 1'b0;
    $display("switch cycle done");
  endtask
  task automatic testShort();
    chanCmp[2].aboveHigh = 1'b1;
    offWindow(2, 1, 6, "short high");
    chanCmp[3].aboveLow = 1'b1;
    tick(8);
    chk(8'(chanEnable[3]), 8'h01, "below 8 V");
    wr(ADDR_CONFIG, 8'h01);
    offWindow(3, 0, 6, "short low");
    wr(ADDR_CONFIG, 8'h03);
    chanCmp[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    tick(8);
    chk(8'(chanEnable[4]), 8'h01, "detect off");
    feedbackStable = 1'b0;
    wr(ADDR_CONFIG, 8'h01);
    tick(8);
    chk(8'(chanEnable[4]), 8'h01, "unstable");
    feedbackStable = 1'b1;
    offWindow(4, 0, 6, "stable again");
    $display("short test done");
  endtask
  task automatic testOpenRegs();
    chanCmp[1] = '{1'b0, 1'b1, 1'b0, 1'b0};
    offWindow(1, OPC - 2, OPC + 6, "open timeout");
    rdChk(ADDR_FAULT, 8'h03, "fault bits");
    rdChk(ADDR_MASK, 8'h1E, "mask shows");
    wr(ADDR_MASK, 8'h1F);
    tick(3);
    chk(chanEnable, 8'hE0, "host mask");
    wr(ADDR_FAULT, 8'hFF);
    rdChk(ADDR_FAULT, 8'h03, "fault read-only");
    rdChk(8'h05, READ_NONE, "unmapped");
    rdChk(ADDR_CONFIG, 8'h01, "config back");
    inputOverCurrent = 1'b1;
    tick(3);
    chk({chanEnable | {7'h0, disconnectEnable}}, 8'h00, "overcurrent");
    inputOverCurrent = 1'b0;
    rdChk(ADDR_FAULT, 8'h0B, "root cause");
    $display("open and register test done");
  endtask
  task automatic testOvp();
    tick(8);
    chk(chanEnable, 8'hFF, "not good kept");
    outputOverVoltage = 1'b1;
    offWindow(7, OPC - 2, OPC + 6, "ovp open");
    outputOverVoltage = 1'b0;
    chk(chanEnable, 8'h3F, "good kept");
    overvoltageSense20 = 1'b1;
    tick(2);
    chk(8'(disconnectEnable), 8'h01, "sense high");
    overvoltageSense20 = 1'b0;
    tick(3);
    chk(8'(disconnectEnable), 8'h00, "sense collapse");
    rdChk(ADDR_FAULT, 8'h25, "collapse cause");
    $display("overvoltage test done");
  endtask
  task automatic testHot();
    tempAboveLow = 1'b1;
    offWindow(6, HTC - 2, HTC + 6, "hot timeout");
    chk(chanEnable, 8'hBF, "hot good kept");
    nodeFail = 1'b1;
    tick(5);
    chk(8'(disconnectEnable), 8'h00, "node low");
    rdChk(ADDR_FAULT, 8'h11, "node cause");
    $display("hot and node test done");
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    supplyLockout = 1'b0;
    regReq = '0;
    chanCmp = '0;
    {overvoltageSense20, outputOverVoltage, tempAboveLow} = 3'h0;
    {inputOverCurrent, feedbackStable, nodeFail, slow} = 4'h0;
    repeat (12) @(posedge mclk);
    #1;
    rstn = 1'b1;
    startUp(8'hFF);
    feedbackStable = 1'b1;
    testSwitch(1'b0, 2, 4);
    testSwitch(1'b1, 6, 8);
    testShort();
    testOpenRegs();
    startUp(8'h3F);
    testOvp();
    startUp(8'hBF);
    testHot();
    finalReport();
  end
endmodule
`default_nettype wire

/* File: tb/lfs_power_stage.sv */
// Model of the power stage and disconnect switch around the supervisor
`timescale 1ns/1ps
`default_nettype none
module lfs_power_stage (
  input  wire logic mclk,
  input  wire logic disconnectEnable,
  input  wire logic prechargeEnable,
  input  wire logic powerSwitchOn,
  input  wire logic nodeFail,
  input  wire logic slow,
  output logic      swCycleTick,
  output logic      switchOverLimit,
  output logic      switchNodeHigh,
  output logic      disconnectFullyOn
);
  logic [3:0] gateDly = 4'h0;
  logic [3:0] tickCnt = 4'h0;
  logic [3:0] onCnt   = 4'h0;
  //////////////////////////////////////////////////////////////////////
  // Slow gate turn-on, cycle timer, inductor current ramp while on
  always_ff @(posedge mclk) begin
    gateDly <= {gateDly[2:0], disconnectEnable};
    tickCnt <= tickCnt + 4'h1;
    onCnt   <= powerSwitchOn ? onCnt + 4'h1 : 4'h0;
  end
  // Comparator outputs seen by the supervisor
  assign disconnectFullyOn = gateDly[3];
  assign swCycleTick       = (tickCnt == 4'hF);
  assign switchOverLimit   = powerSwitchOn
                             && (onCnt >= (slow ? 4'h6 : 4'h2));
  assign switchNodeHigh    = !nodeFail
                             && (prechargeEnable || disconnectFullyOn);
endmodule
`default_nettype wire
